/* File: rtl/nand_multi_cache_host.sv */
// host sequencer for two-district, cached and page copy programming of a nand flash
`timescale 1ns/10ps
`default_nettype none
module nand_multi_cache_host
  #(parameter int WB_WAIT = nand_seq_pkg::WB_CYCLES)
   (input  wire logic                                core_clk_i,
    input  wire logic                                rst_i,
    input  wire logic                                op_valid_i,
    input  wire nand_seq_pkg::op_e                   op_i,
    input  wire logic                                op_last_i,
    input  wire logic [nand_seq_pkg::BLOCK_BITS-1:0] blk_a_i,
    input  wire logic [nand_seq_pkg::BLOCK_BITS-1:0] blk_b_i,
    input  wire logic [nand_seq_pkg::BLOCK_BITS-1:0] src_blk_i,
    input  wire logic [nand_seq_pkg::PAGE_BITS-1:0]  page_addr_bits_i,
    input  wire logic [nand_seq_pkg::PAGE_BITS-1:0]  src_page_i,
    input  wire logic [15:0]                         col_i,
    input  wire logic [15:0]                         byte_count_i,
    output logic                                     op_ready_o,
    output logic                                     data_ready_o,
    input  wire logic                                data_valid_i,
    input  wire logic [7:0]                          data_i,
    output logic                                     done_o,
    output logic                                     fail_o,
    output logic                                     prev_fail_o,
    output logic                                     addr_err_o,
    output logic [7:0]                               status_o,
    output logic                                     cmd_latch_o,
    output logic                                     addr_latch_o,
    output logic                                     chip_enable_n_o,
    output logic                                     write_strobe_n_o,
    output logic                                     read_strobe_n_o,
    output logic                                     write_protect_n_o,
    output logic [7:0]                               io_o,
    output logic                                     io_oe_o,
    input  wire logic [7:0]                          io_i,
    input  wire logic                                ready_busy_out_i);
   import nand_seq_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE, S_CMD, S_ADDR, S_DATA, S_WAIT_WB, S_WAIT_RDY, S_STAT_CMD, S_STAT_RD, S_DONE
   } state_e;
   typedef enum logic [2:0] {
      N_SRC_ADDR, N_SRC_CONF, N_ADDR1, N_DATA1, N_MID, N_ADDR2, N_DATA2, N_CONF
   } step_e;
   typedef struct packed {
      state_e     state;
      step_e      step;
      op_e        op;
      logic       last;
      logic       first_dist;
      logic [2:0] acnt;
      logic [15:0] bcnt;
      logic [7:0] wcnt;
      logic [7:0] cmd;
      logic [7:0] stat;
      logic [BLOCK_BITS-1:0] blk;
      logic [BLOCK_BITS-1:0] run_blk;
      logic       run_open;
      logic       done;
      logic       aerr;
   } host_s;
   host_s cur;
   host_s next_cur;

   logic       bc_start;
   logic       bc_rd;
   logic       bc_cmd;
   logic       bc_addr;
   logic [7:0] bc_wdata;
   logic       bc_done;
   logic [7:0] bc_rdata;
   logic       rs_n;
   logic [39:0] addr_word;
   logic        dist_ok;

   localparam logic [7:0] WB_LAST = 8'(WB_WAIT - 1);
   localparam logic [2:0] ADDR_LAST = 3'(ADDR_CYCLES - 1);

   always_comb
   begin
      addr_word = {7'h00, cur.blk, page_addr_bits_i, col_i};
      if (cur.step == N_SRC_ADDR)
         addr_word = {7'h00, src_blk_i, src_page_i, col_i};
   end

   // copy keeps source and target in one district; two-district needs one per district
   assign dist_ok = (op_i == OP_PAGE_COPY) ? (src_blk_i[DIST_BIT] == blk_a_i[DIST_BIT])
                  : (op_i == OP_CACHE_PROG) ? 1'b1
                  : (blk_a_i[DIST_BIT] != blk_b_i[DIST_BIT]);

   always_comb
   begin
      next_cur = cur;
      next_cur.done = 1'b0;
      bc_start = 1'b0;
      bc_rd = 1'b0;
      bc_cmd = 1'b0;
      bc_addr = 1'b0;
      bc_wdata = 8'h00;
      unique case (cur.state)
         S_IDLE:
         begin
            if (op_valid_i)
            begin
               next_cur.op = op_i;
               next_cur.last = op_last_i;
               next_cur.aerr = !dist_ok;
               next_cur.blk = blk_a_i;
               next_cur.first_dist = 1'b1;
               // a new block (or a fresh run) starts the whole sequence again
               if (!cur.run_open || (cur.run_blk != blk_a_i))
                  next_cur.run_open = 1'b0;
               next_cur.run_blk = blk_a_i;
               if (dist_ok)
               begin
                  next_cur.state = S_CMD;
                  if (op_i == OP_PAGE_COPY)
                  begin
                     next_cur.cmd = CMD_READ_SETUP;
                     next_cur.step = N_SRC_ADDR;
                  end
                  else
                  begin
                     next_cur.cmd = CMD_DATA_SETUP;
                     next_cur.step = N_ADDR1;
                  end
               end
               else
                  next_cur.done = 1'b1;
            end
         end
         S_CMD:
         begin
            bc_start = 1'b1;
            bc_cmd = 1'b1;
            bc_wdata = cur.cmd;
            next_cur.state = S_DATA;
            next_cur.bcnt = 16'hFFFF;
         end
         S_ADDR:
         begin
            bc_start = 1'b1;
            bc_addr = 1'b1;
            bc_wdata = addr_word[8*cur.acnt +: 8];
            next_cur.state = S_DATA;
            next_cur.bcnt = 16'hFFFE;
         end
         S_DATA:
         begin
            if (cur.bcnt < 16'hFFFE)
            begin
               bc_start = !bc_done && data_valid_i && (cur.bcnt != 16'h0000) && cur.wcnt == 8'h00;
               bc_wdata = data_i;
               if (bc_start)
                  next_cur.wcnt = 8'h01;
            end
            if (bc_done)
            begin
               next_cur.wcnt = 8'h00;
               if (cur.bcnt == 16'hFFFE)
               begin
                  next_cur.acnt = cur.acnt + 3'h1;
                  next_cur.state = S_ADDR;
                  if (cur.acnt == ADDR_LAST)
                  begin
                     next_cur.acnt = 3'h0;
                     next_cur.state = S_DATA;
                     // source read address goes straight to 3Ah, no data bytes
                     next_cur.bcnt = (cur.step == N_SRC_ADDR) ? 16'h0000 : byte_count_i;
                  end
               end
               else if (cur.bcnt == 16'hFFFF)
               begin
                  next_cur.state = S_ADDR;
                  next_cur.acnt = 3'h0;
                  if ((cur.cmd == CMD_PROG_CONFIRM) || (cur.cmd == CMD_CACHE_CONF)
                      || (cur.cmd == CMD_COPY_READ) || (cur.cmd == CMD_DIST1_DONE))
                  begin
                     next_cur.state = S_WAIT_WB;
                     next_cur.wcnt = 8'h00;
                  end
               end
               else
                  next_cur.bcnt = cur.bcnt - 16'h0001;
            end
            // data phase complete (zero bytes skips it entirely)
            if ((cur.bcnt == 16'h0000) && (cur.wcnt == 8'h00))
            begin
               next_cur.state = S_CMD;
               unique case (cur.step)
                  N_SRC_ADDR:
                  begin
                     next_cur.cmd = CMD_COPY_READ;
                     next_cur.step = N_SRC_CONF;
                  end
                  N_ADDR1:
                  begin
                     if (cur.op == OP_CACHE_PROG)
                     begin
                        next_cur.cmd = cur.last ? CMD_PROG_CONFIRM : CMD_CACHE_CONF;
                        next_cur.step = N_CONF;
                     end
                     else if (cur.op == OP_PAGE_COPY)
                     begin
                        next_cur.cmd = cur.last ? CMD_PROG_CONFIRM : CMD_CACHE_CONF;
                        next_cur.step = N_CONF;
                     end
                     else
                     begin
                        next_cur.cmd = CMD_DIST1_DONE;
                        next_cur.step = N_MID;
                     end
                  end
                  default:
                  begin
                     // full block run ends with 81h then 10h
                     next_cur.cmd = (cur.op == OP_MULTI_PROG || cur.last) ? CMD_PROG_CONFIRM
                                  : CMD_CACHE_CONF;
                     next_cur.step = N_CONF;
                  end
               endcase
            end
         end
         S_WAIT_WB:
         begin
            next_cur.wcnt = cur.wcnt + 8'h01;
            if (cur.wcnt == WB_LAST)
            begin
               next_cur.wcnt = 8'h00;
               next_cur.state = S_WAIT_RDY;
            end
         end
         S_WAIT_RDY:
         begin
            // device programs and verifies on its own; wait for ready before the next command
            if (ready_busy_out_i)
            begin
               if (cur.step == N_SRC_CONF)
               begin
                  next_cur.state = S_CMD;
                  next_cur.cmd = CMD_COPY_SETUP;
                  next_cur.step = N_ADDR1;
               end
               else if (cur.step == N_MID)
               begin
                  // only the second-district setup follows 11h
                  next_cur.state = S_CMD;
                  next_cur.cmd = CMD_DIST2_SETUP;
                  next_cur.step = N_ADDR2;
                  next_cur.blk = blk_b_i;
               end
               else
               begin
                  next_cur.state = S_STAT_CMD;
                  next_cur.cmd = (cur.op == OP_CACHE_PROG || cur.op == OP_PAGE_COPY)
                               ? CMD_STATUS : CMD_DIST_STATUS;
               end
            end
         end
         S_STAT_CMD:
         begin
            bc_start = !bc_done && cur.wcnt == 8'h00;
            bc_cmd = 1'b1;
            bc_wdata = cur.cmd;
            if (bc_start)
               next_cur.wcnt = 8'h01;
            if (bc_done)
            begin
               next_cur.wcnt = 8'h00;
               next_cur.state = S_STAT_RD;
            end
         end
         S_STAT_RD:
         begin
            bc_start = !bc_done && cur.wcnt == 8'h00;
            bc_rd = 1'b1;
            if (bc_start)
               next_cur.wcnt = 8'h01;
            if (bc_done)
            begin
               next_cur.wcnt = 8'h00;
               next_cur.stat = bc_rdata;
               next_cur.state = S_DONE;
            end
         end
         S_DONE:
         begin
            next_cur.done = 1'b1;
            next_cur.run_open = !cur.last && (cur.op != OP_MULTI_PROG);
            next_cur.state = S_IDLE;
         end
         default:
            next_cur.state = S_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         cur <= '{state: S_IDLE, step: N_ADDR1, op: OP_MULTI_PROG, default: '0};
      else
         cur <= next_cur;
   end

   nand_bus_cycle u_cycle
     (.core_clk_i       (core_clk_i),
      .rst_i            (rst_i),
      .start_i          (bc_start),
      .is_read_i        (bc_rd),
      .is_cmd_i         (bc_cmd),
      .is_addr_i        (bc_addr),
      .wdata_i          (bc_wdata),
      .done_o           (bc_done),
      .rdata_o          (bc_rdata),
      .cmd_latch_o      (cmd_latch_o),
      .addr_latch_o     (addr_latch_o),
      .write_strobe_n_o (write_strobe_n_o),
      .read_strobe_n_o  (rs_n),
      .io_o             (io_o),
      .io_oe_o          (io_oe_o),
      .io_i             (io_i));

   assign read_strobe_n_o = rs_n;
   assign chip_enable_n_o = (cur.state == S_IDLE) && !cur.run_open;
   assign write_protect_n_o = 1'b1;
   assign op_ready_o = (cur.state == S_IDLE);
   assign data_ready_o = (cur.state == S_DATA) && (cur.bcnt < 16'hFFFE) && (cur.bcnt != 16'h0000)
                       && (cur.wcnt == 8'h00) && !bc_done;
   assign done_o = cur.done;
   assign addr_err_o = cur.done && cur.aerr;
   assign status_o = cur.stat;
   // plain status: bit0 current/overall, bit1 previous gated by bit6 cache ready; district status: OR of districts
   assign fail_o = (cur.cmd == CMD_DIST_STATUS)
                 ? (cur.stat[ST_FAIL] | cur.stat[ST_D0_FAIL] | cur.stat[ST_D1_FAIL])
                 : cur.stat[ST_FAIL];
   assign prev_fail_o = (cur.cmd == CMD_DIST_STATUS)
                      ? (cur.stat[ST_D0_PREV] | cur.stat[ST_D1_PREV])
                      : (cur.stat[ST_PREV_FAIL] & cur.stat[ST_CACHE_RDY]);

   a_mid_only_81: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cur.state == S_WAIT_RDY && cur.step == N_MID && ready_busy_out_i)
      |=> cur.cmd == CMD_DIST2_SETUP)
      else $error("command after 11h is not 81h");
   a_wp_held: assert property (@(posedge core_clk_i) disable iff (rst_i)
      write_protect_n_o)
      else $error("write protect asserted");
   a_no_cmd_busy: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cur.state == S_WAIT_RDY && !ready_busy_out_i) |=> cur.state == S_WAIT_RDY)
      else $error("left wait while busy");
   a_copy_src_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cur.state == S_CMD && cur.step == N_SRC_CONF) |-> cur.cmd == CMD_COPY_READ)
      else $error("copy read confirm wrong");
   a_last_confirm: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cur.state == S_CMD && cur.step == N_CONF && cur.last) |-> cur.cmd == CMD_PROG_CONFIRM)
      else $error("last page not confirmed with 10h");
   a_mid_confirm: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cur.state == S_CMD && cur.step == N_CONF && !cur.last && cur.op != OP_MULTI_PROG)
      |-> cur.cmd == CMD_CACHE_CONF)
      else $error("cache page not confirmed with 15h");
   a_dist_differ: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (op_valid_i && op_ready_o && (op_i == OP_MULTI_CACHE || op_i == OP_MULTI_PROG)
       && blk_a_i[DIST_BIT] == blk_b_i[DIST_BIT])
      |=> cur.state == S_IDLE)
      else $error("same district pair issued");
   a_done_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
      done_o |=> !done_o)
      else $error("done longer than one cycle");
endmodule
`default_nettype wire

/* File: rtl/nand_seq_pkg.sv */
// package: command codes, status bits, timing and address layout for the nand sequencer host
// Function
// - between 11h and 81h only 70h/FFh
// - 15h after data starts cached program
// - 10h ends cache run; ready means done
// - block change restarts the sequence
// - full block: 64 pages, end 81h-10h
// - one block per district, same page
// - cached two-district ends with 10h
// - page copy data only where changed
// - page copy stays in one district
// - write protect high, end 8Ch-10h
// - copy source read is 00h then 3Ah
// - copy program 8Ch, 15h middle, 10h last
package nand_seq_pkg;
   localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
   localparam logic [7:0] CMD_COPY_READ    = 8'h3A;
   localparam logic [7:0] CMD_DATA_SETUP   = 8'h80;
   localparam logic [7:0] CMD_DIST2_SETUP  = 8'h81;
   localparam logic [7:0] CMD_COPY_SETUP   = 8'h8C;
   localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
   localparam logic [7:0] CMD_DIST1_DONE   = 8'h11;
   localparam logic [7:0] CMD_CACHE_CONF   = 8'h15;
   localparam logic [7:0] CMD_STATUS       = 8'h70;
   localparam logic [7:0] CMD_DIST_STATUS  = 8'h71;
   localparam logic [7:0] CMD_RESET        = 8'hFF;

   localparam int ST_FAIL      = 0;
   localparam int ST_PREV_FAIL = 1;
   localparam int ST_D0_FAIL   = 1;
   localparam int ST_D1_FAIL   = 2;
   localparam int ST_D0_PREV   = 3;
   localparam int ST_D1_PREV   = 4;
   localparam int ST_READY     = 5;
   localparam int ST_CACHE_RDY = 6;
   localparam int ST_NOT_WP    = 7;

   localparam int PAGES_PER_BLOCK = 64;
   localparam int PAGE_BITS       = 6;
   localparam int BLOCK_BITS      = 11;
   localparam int DIST_BIT        = 0;
   localparam int ADDR_CYCLES     = 5;
   localparam int COL_CYCLES      = 2;

   localparam int CLK_PERIOD_PS  = 4000;
   localparam int T_STROBE_NS    = 12;
   localparam int STROBE_CYCLES  = (T_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_WB_NS        = 100;
   localparam int WB_CYCLES      = (T_WB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      OP_MULTI_PROG = 2'h0,
      OP_CACHE_PROG = 2'h1,
      OP_MULTI_CACHE = 2'h2,
      OP_PAGE_COPY  = 2'h3
   } op_e;
endpackage

/* File: rtl/nand_bus_cycle.sv */
// one strobed bus cycle on the nand pins: command, address, data write or data read
`timescale 1ns/10ps
`default_nettype none
module nand_bus_cycle
  #(parameter int HOLD = nand_seq_pkg::STROBE_CYCLES)
   (input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic       is_read_i,
    input  wire logic       is_cmd_i,
    input  wire logic       is_addr_i,
    input  wire logic [7:0] wdata_i,
    output logic            done_o,
    output logic [7:0]      rdata_o,
    output logic            cmd_latch_o,
    output logic            addr_latch_o,
    output logic            write_strobe_n_o,
    output logic            read_strobe_n_o,
    output logic [7:0]      io_o,
    output logic            io_oe_o,
    input  wire logic [7:0] io_i);
   import nand_seq_pkg::*;

   typedef enum logic [1:0] {B_IDLE, B_LOW, B_HIGH} bphase_e;
   typedef struct packed {
      bphase_e    phase;
      logic [7:0] cnt;
      logic       rd;
      logic       cle;
      logic       ale;
      logic [7:0] dout;
      logic [7:0] din;
      logic       done;
   } bus_s;
   bus_s cur;
   bus_s next_cur;
   localparam logic [7:0] LAST = 8'(HOLD - 1);

   always_comb
   begin
      next_cur = cur;
      next_cur.done = 1'b0;
      unique case (cur.phase)
         B_IDLE:
         begin
            if (start_i)
            begin
               next_cur.phase = B_LOW;
               next_cur.cnt = '0;
               next_cur.rd = is_read_i;
               next_cur.cle = is_cmd_i;
               next_cur.ale = is_addr_i;
               next_cur.dout = wdata_i;
            end
         end
         B_LOW:
         begin
            next_cur.cnt = cur.cnt + 8'h01;
            if (cur.cnt == LAST)
            begin
               next_cur.cnt = '0;
               next_cur.phase = B_HIGH;
               if (cur.rd)
                  next_cur.din = io_i;
            end
         end
         B_HIGH:
         begin
            next_cur.cnt = cur.cnt + 8'h01;
            if (cur.cnt == LAST)
            begin
               next_cur.phase = B_IDLE;
               next_cur.done = 1'b1;
               next_cur.cle = 1'b0;
               next_cur.ale = 1'b0;
            end
         end
         default:
            next_cur.phase = B_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         cur <= '{phase: B_IDLE, default: '0};
      else
         cur <= next_cur;
   end

   assign done_o = cur.done;
   assign rdata_o = cur.din;
   assign cmd_latch_o = cur.cle;
   assign addr_latch_o = cur.ale;
   assign write_strobe_n_o = !((cur.phase == B_LOW) && !cur.rd);
   assign read_strobe_n_o = !((cur.phase == B_LOW) && cur.rd);
   assign io_o = cur.dout;
   assign io_oe_o = (cur.phase != B_IDLE) && !cur.rd;

   a_strobe_low_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $fell(cur.phase == B_LOW) |-> $past(cur.cnt) == LAST)
      else $error("strobe low time wrong");
   a_read_no_drive: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !read_strobe_n_o |-> !io_oe_o)
      else $error("bus driven during read strobe");
endmodule
`default_nettype wire

/* File: dv/nand_dev_model.sv */
// device model: busy timing, district tracking and status bytes of the flash
`timescale 1ns/10ps
`default_nettype none
module nand_dev_model
  #(parameter int BUSY = 8)
   (input  wire logic       core_clk_i,
    input  wire logic       cmd_latch_i,
    input  wire logic       addr_latch_i,
    input  wire logic       write_strobe_n_i,
    input  wire logic       read_strobe_n_i,
    input  wire logic [7:0] io_i,
    input  wire logic [1:0] fail_i,
    output logic            ready_busy_out_o,
    output logic [7:0]      io_o,
    output logic [7:0]      last_cmd_o,
    output logic [7:0]      ndata_o);
   logic       we_q = 1'b1;
   logic       ended = 1'b1;
   logic [7:0] busy = 8'h00;
   logic [2:0] acnt = 3'h0;
   logic [1:0] used = 2'h0;
   logic [1:0] cur = 2'h0;
   logic [1:0] prev = 2'h0;
   logic [7:0] lcmd = 8'h00;
   logic [7:0] last_io = 8'h00;
   logic [7:0] nd = 8'h00;
   logic [7:0] st;
   assign last_cmd_o = lcmd;
   assign ndata_o = nd;
   assign ready_busy_out_o = (busy == 8'h00);
   always_comb
   begin
      if (lcmd == 8'h71)
         st = {1'b1, {2{ready_busy_out_o}}, prev, cur, |cur};
      else
         st = {1'b1, {2{ready_busy_out_o}}, 3'h0, |prev, |cur};
   end
   // released bus shows the inverse of the last byte
   assign io_o = !read_strobe_n_i ? st : ~last_io;
   always_ff @(posedge core_clk_i)
   begin
      we_q <= write_strobe_n_i;
      if (!read_strobe_n_i) last_io <= st;
      if (busy != 8'h00) busy <= busy - 8'h01;
      if (write_strobe_n_i && !we_q && cmd_latch_i)
      begin
         lcmd <= io_i;
         acnt <= 3'h0;
         if (io_i inside {8'h80, 8'h8C, 8'h00}) used <= 2'h0;
         if (io_i inside {8'h80, 8'h00}) nd <= 8'h00;
         if (ended && io_i inside {8'h80, 8'h00}) {cur, prev, ended} <= 5'h00;
         if (io_i inside {8'h11, 8'h3A}) busy <= BUSY[7:0];
         if (io_i inside {8'h10, 8'h15})
         begin
            cur <= fail_i & used;
            prev <= cur;
            ended <= (io_i == 8'h10);
            busy <= BUSY[7:0];
         end
      end
      if (write_strobe_n_i && !we_q && addr_latch_i)
      begin
         acnt <= acnt + 3'h1;
         if (acnt == 3'h2) used[io_i[6]] <= 1'b1;
      end
      if (write_strobe_n_i && !we_q && !cmd_latch_i && !addr_latch_i) nd <= nd + 8'h01;
   end
endmodule
`default_nettype wire

/* File: dv/nand_multi_cache_program_copy_tb.sv */
// testbench: programming sequences of the host against the flash model
`timescale 1ns/10ps
`default_nettype none
module nand_multi_cache_program_copy_tb;
   import nand_seq_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        op_valid = 1'b0;
   op_e         op = OP_MULTI_PROG;
   logic        last = 1'b1;
   logic [10:0] blk_a = 11'h000;
   logic [10:0] blk_b = 11'h000;
   logic [5:0]  pg = 6'h00;
   logic [15:0] cnt = 16'h0000;
   logic [1:0]  fail_in = 2'h0;
   logic [7:0]  data = 8'h00;
   logic        dval = 1'b0;
   logic        op_ready, data_ready, done, fail, prev_fail, addr_err;
   logic        cle, ale, ce_n, we_n, re_n, wp_n, oe, rb;
   logic [7:0]  status, hio, dio, host_in, last_cmd, ndata;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cyc = 0;
   assign host_in = oe ? hio : dio;
   nand_multi_cache_host #(.WB_WAIT(2)) nand_multi_cache_host_i
      (.core_clk_i(clk), .rst_i(rst), .op_valid_i(op_valid), .op_i(op), .op_last_i(last),
       .blk_a_i(blk_a), .blk_b_i(blk_b), .src_blk_i(blk_b), .page_addr_bits_i(pg),
       .src_page_i(pg), .col_i(16'h0000), .byte_count_i(cnt), .op_ready_o(op_ready),
       .data_ready_o(data_ready), .data_valid_i(dval), .data_i(data), .done_o(done),
       .fail_o(fail), .prev_fail_o(prev_fail), .addr_err_o(addr_err), .status_o(status),
       .cmd_latch_o(cle), .addr_latch_o(ale), .chip_enable_n_o(ce_n),
       .write_strobe_n_o(we_n), .read_strobe_n_o(re_n), .write_protect_n_o(wp_n),
       .io_o(hio), .io_oe_o(oe), .io_i(host_in), .ready_busy_out_i(rb));
   nand_dev_model nand_dev_model_i
      (.core_clk_i(clk), .cmd_latch_i(cle), .addr_latch_i(ale), .write_strobe_n_i(we_n),
       .read_strobe_n_i(re_n), .io_i(hio), .fail_i(fail_in), .ready_busy_out_o(rb),
       .io_o(dio), .last_cmd_o(last_cmd), .ndata_o(ndata));
   initial
      forever #2 clk = ~clk;
   always @(posedge clk)
   begin
      dval <= ~dval;
      if (data_ready && dval) data <= data + 8'h01;
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic run(input string name, input op_e o, input logic [10:0] a,
                      input logic [10:0] b, input logic [1:0] f, input logic l,
                      input logic [15:0] n, input logic [7:0] s, input logic e);
      int  k;
      logic two;
      logic pf;
      two = (o == OP_MULTI_PROG) || (o == OP_MULTI_CACHE);
      pf = two ? (s[3] | s[4]) : s[1];
      @(posedge clk);
      op <= o;
      {blk_a, blk_b, fail_in, last, cnt} <= {a, b, f, l, n};
      pg <= pg + 6'h01;
      op_valid <= 1'b1;
      @(negedge clk);
      for (k = 0; k < 100 && op_ready !== 1'b1; k++) @(negedge clk);
      @(posedge clk);
      op_valid <= 1'b0;
      @(negedge clk);
      if (!e) check({name, " ce_n"}, {7'h00, ce_n}, 8'h00);
      for (k = 0; k < 8000 && done !== 1'b1; k++) @(negedge clk);
      if (done !== 1'b1) error_cnt++;
      check({name, " addr_err"}, {7'h00, addr_err}, {7'h00, e});
      check({name, " wp_n"}, {7'h00, wp_n}, 8'h01);
      if (!e)
      begin
         check({name, " status"}, status, s);
         check({name, " fail"}, {7'h00, fail}, {7'h00, s[0]});
         check({name, " status cmd"}, last_cmd, two ? 8'h71 : 8'h70);
         check({name, " prev_fail"}, {7'h00, prev_fail}, {7'h00, pf});
         check({name, " data bytes"}, ndata, two ? {n[6:0], 1'b0} : n[7:0]);
      end
      $display("test %s finished", name);
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      run("multi pass", OP_MULTI_PROG, 11'h002, 11'h003, 2'h0, 1'b1, 16'h0002, 8'hE0, 1'b0);
      run("multi d1 fail", OP_MULTI_PROG, 11'h004, 11'h005, 2'h2, 1'b1, 16'h0002, 8'hE5, 1'b0);
      run("multi swapped", OP_MULTI_PROG, 11'h007, 11'h006, 2'h0, 1'b1, 16'h0001, 8'hE0, 1'b0);
      run("multi same", OP_MULTI_PROG, 11'h008, 11'h00A, 2'h0, 1'b1, 16'h0001, 8'h00, 1'b1);
      run("cache first", OP_CACHE_PROG, 11'h00C, 11'h000, 2'h1, 1'b0, 16'h0003, 8'hE1, 1'b0);
      run("cache last", OP_CACHE_PROG, 11'h00C, 11'h000, 2'h0, 1'b1, 16'h0003, 8'hE2, 1'b0);
      run("copy mid", OP_PAGE_COPY, 11'h010, 11'h00E, 2'h1, 1'b0, 16'h0002, 8'hE1, 1'b0);
      run("copy same", OP_PAGE_COPY, 11'h010, 11'h00E, 2'h0, 1'b1, 16'h0000, 8'hE2, 1'b0);
      run("copy cross", OP_PAGE_COPY, 11'h010, 11'h00F, 2'h0, 1'b1, 16'h0000, 8'h00, 1'b1);
      run("mc mid", OP_MULTI_CACHE, 11'h002, 11'h003, 2'h2, 1'b0, 16'h0001, 8'hE5, 1'b0);
      run("mc last", OP_MULTI_CACHE, 11'h002, 11'h003, 2'h1, 1'b1, 16'h0002, 8'hF3, 1'b0);
      end_sim();
   end
endmodule
`default_nettype wire
